// File: psi_pkg.sv
// Package: offsets, field positions, reset values and timing counts
package psi_pkg;
    // Port addresses
    localparam logic [7:0] PSI_ADDR_GIM  = 8'h20;
    localparam logic [7:0] PSI_ADDR_EIM  = 8'h21;
    localparam logic [7:0] PSI_ADDR_PSC  = 8'hff;
    // Status/control field positions
    localparam int PSC_RUN      = 0;
    localparam int PSC_RSVD     = 1;
    localparam int PSC_IE_SENSE = 2;
    localparam int PSC_SUSPEND  = 3;
    localparam int PSC_POR      = 4;
    localparam int PSC_BUSRST   = 5;
    localparam int PSC_WDOG     = 6;
    localparam int PSC_PENDING  = 7;
    // Reset value and write masks
    localparam logic [7:0] PSC_RESET_VAL = 8'h11;
    localparam logic [7:0] GIM_WMASK     = 8'h77;
    localparam logic [7:0] EIM_WMASK     = 8'h1f;
    // Source indices, lowest index is highest priority
    localparam int SRC_BUSRST = 0;
    localparam int SRC_T128   = 1;
    localparam int SRC_T1024  = 2;
    localparam int SRC_EP0    = 3;
    localparam int SRC_DAC    = 8;
    localparam int SRC_GPIO   = 9;
    localparam int SRC_I2C    = 10;
    localparam int SRC_NUM    = 11;
    // Bus reset timing: single-ended zero of at least 12 us
    localparam int SE0_MIN_NS  = 12000;
    localparam int CLK_NS      = 10;
    localparam int SE0_CYCLES  = (SE0_MIN_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {PSI_RUN, PSI_SUSP, PSI_HALT} psi_mode_t;
endpackage

// File: psi_src_pend.sv
// Per-source pending flip-flops with priority pick
`timescale 1ns/1ns
module psi_src_pend
    import psi_pkg::*;
#(
    parameter int N = SRC_NUM
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    // Events and masks
    input  wire logic [N-1:0] event_in,
    input  wire logic [N-1:0] enable_in,
    input  wire logic         ack_in,
    // Status
    output logic [N-1:0]      pending_out,
    output logic              request_out,
    output logic [3:0]        vector_out
);
    if (N < 1 || N > 15) begin : g_bad_n
        $error("psi_src_pend: N out of range");
    end

    typedef struct packed {
        logic [N-1:0] pend;
    } psi_sp_t;

    psi_sp_t st;
    psi_sp_t next_st;
    logic [N-1:0] req;
    logic [3:0]   sel;

    assign req = st.pend & enable_in;

    always_comb begin
        sel = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) sel = 4'(i);
        end
    end

    always_comb begin
        next_st = st;
        for (int i = 0; i < N; i++) begin
            if (ack_in && |req && sel == 4'(i)) next_st.pend[i] = 1'b0;
            if (event_in[i]) next_st.pend[i] = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pending_out = st.pend;
    assign request_out = |req;
    assign vector_out  = sel + 4'h1;
endmodule // psi_src_pend

// File: psi_core.sv
// Processor status/control and interrupt enable registers
`timescale 1ns/1ns
module psi_core
    import psi_pkg::*;
#(
    parameter int SE0_CNT = SE0_CYCLES
) (
    // Clock and power-on reset
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // Watchdog reset pulse from the timer
    input  wire logic       watchdog_cause_in,
    // Port instruction access
    input  wire logic       port_write_instruction_in,
    input  wire logic       port_read_in,
    input  wire logic [7:0] port_addr_in,
    input  wire logic [7:0] port_wdata_in,
    output logic [7:0]      port_rdata_out,
    // Core instructions
    input  wire logic       irq_off_instruction_in,
    input  wire logic       irq_on_instruction_in,
    input  wire logic       irq_return_instruction_in,
    input  wire logic       stop_instruction_in,
    input  wire logic       instr_end_in,
    // Upstream USB lines, asynchronous
    input  wire logic       usb_dp_in,
    input  wire logic       usb_dm_in,
    input  wire logic       bus_activity_in,
    // Interrupt event pulses
    input  wire logic       tick_128us_in,
    input  wire logic       tick_1024us_in,
    input  wire logic [4:0] endpoint_event_in,
    input  wire logic       dac_event_in,
    input  wire logic       gpio_event_in,
    input  wire logic       i2c_event_in,
    // Core control
    output logic            run_out,
    output logic            suspend_out,
    output logic            irq_call_out,
    output logic [3:0]      irq_vector_out,
    output logic            bus_reset_out
);
    if (SE0_CNT < 1 || SE0_CNT > 65535) begin : g_bad_se0
        $error("psi_core: bad SE0_CNT");
    end

    typedef struct packed {
        logic [7:0]  psc;
        logic [7:0]  gim;
        logic [7:0]  eim;
        psi_mode_t   mode;
        logic [1:0]  dp_sync;
        logic [1:0]  dm_sync;
        logic [1:0]  act_sync;
        logic [15:0] se0_cnt;
        logic        se0_seen;
        logic        bus_irq;
        logic        call;
        logic [3:0]  vec;
        logic [7:0]  rdata;
    } psi_st_t;

    psi_st_t st;
    psi_st_t next_st;

    logic [SRC_NUM-1:0] events;
    logic [SRC_NUM-1:0] enables;
    logic [SRC_NUM-1:0] pend;
    logic               req;
    logic [3:0]         vec;
    logic               se0;
    logic               active;
    logic               take;

    function automatic logic hit(input logic [7:0] a);
        return port_write_instruction_in && port_addr_in == a;
    endfunction

    assign se0 = !st.dp_sync[1] && !st.dm_sync[1];
    assign active = st.act_sync[1] || se0;

    assign events = {i2c_event_in, gpio_event_in, dac_event_in,
                     endpoint_event_in, tick_1024us_in, tick_128us_in,
                     st.bus_irq};
    assign enables = {st.gim[6], st.gim[5], st.gim[4], st.eim[4:0],
                      st.gim[2], st.gim[1], st.gim[0]};

    assign take = st.psc[PSC_IE_SENSE] && req && instr_end_in
                  && st.mode == PSI_RUN;

    psi_src_pend #(
        .N (SRC_NUM)
    ) u_pend (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .event_in    (events),
        .enable_in   (enables),
        .ack_in      (take),
        .pending_out (pend),
        .request_out (req),
        .vector_out  (vec)
    );

    always_comb begin
        next_st = st;
        next_st.dp_sync  = {st.dp_sync[0], usb_dp_in};
        next_st.dm_sync  = {st.dm_sync[0], usb_dm_in};
        next_st.act_sync = {st.act_sync[0], bus_activity_in};
        next_st.call     = 1'b0;
        next_st.bus_irq  = 1'b0;

        if (se0) begin
            if (st.se0_cnt < 16'(SE0_CNT)) next_st.se0_cnt = st.se0_cnt + 16'h1;
            else next_st.se0_seen = 1'b1;
        end else begin
            next_st.se0_cnt  = '0;
            next_st.se0_seen = 1'b0;
            next_st.bus_irq  = st.se0_seen;
        end

        // Firmware writes to enables
        // cleared by the watchdog cause below and by reset
        if (hit(PSI_ADDR_GIM)) next_st.gim = port_wdata_in & GIM_WMASK;
        if (hit(PSI_ADDR_EIM)) next_st.eim = port_wdata_in & EIM_WMASK;

        if (hit(PSI_ADDR_PSC)) begin
            next_st.psc[PSC_RUN]  = port_wdata_in[PSC_RUN];
            next_st.psc[PSC_RSVD] = port_wdata_in[PSC_RSVD];
            next_st.psc[PSC_POR]    = port_wdata_in[PSC_POR];
            next_st.psc[PSC_BUSRST] = port_wdata_in[PSC_BUSRST];
            next_st.psc[PSC_WDOG]   = port_wdata_in[PSC_WDOG];
            if (port_wdata_in[PSC_SUSPEND] && !active) begin
                next_st.psc[PSC_SUSPEND] = 1'b1;
                next_st.mode = PSI_SUSP;
            end else begin
                next_st.psc[PSC_SUSPEND] = 1'b0;
            end
        end

        if (irq_on_instruction_in || irq_return_instruction_in)
            next_st.psc[PSC_IE_SENSE] = 1'b1;
        if (irq_off_instruction_in)
            next_st.psc[PSC_IE_SENSE] = 1'b0;

        if (take) begin
            next_st.psc[PSC_IE_SENSE] = 1'b0;
            next_st.call = 1'b1;
            next_st.vec  = vec;
        end

        if (st.mode == PSI_SUSP && (req || active)) begin
            next_st.mode = PSI_RUN;
            next_st.psc[PSC_SUSPEND] = 1'b0;
        end

        next_st.psc[PSC_PENDING] = |pend;

        if (stop_instruction_in && st.mode == PSI_RUN) begin
            next_st.psc  = '0;
            next_st.mode = PSI_HALT;
        end

        if (watchdog_cause_in) begin
            next_st.psc = {1'b0, 1'b1, st.psc[PSC_BUSRST], st.psc[PSC_POR],
                           4'h1};
            next_st.gim  = '0;
            next_st.eim  = '0;
            next_st.mode = PSI_RUN;
            next_st.call = 1'b0;
        end

        // record bus reset, set wins over clears
        if (se0 && st.se0_cnt == 16'(SE0_CNT - 1))
            next_st.psc[PSC_BUSRST] = 1'b1;

        next_st.rdata = 8'h00;
        if (port_read_in) begin
            case (port_addr_in)
                PSI_ADDR_GIM: next_st.rdata = st.gim;
                PSI_ADDR_EIM: next_st.rdata = st.eim;
                PSI_ADDR_PSC: next_st.rdata = st.psc;
                default:      next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st      <= '0;
            st.psc  <= PSC_RESET_VAL;
            st.mode <= PSI_RUN;
            st.dp_sync <= 2'h3;
            st.dm_sync <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    assign port_rdata_out = st.rdata;
    assign run_out        = st.mode == PSI_RUN;
    assign suspend_out    = st.mode == PSI_SUSP;
    assign irq_call_out   = st.call;
    assign irq_vector_out = st.vec;
    assign bus_reset_out  = st.bus_irq;
endmodule // psi_core

// File: psi_core_sva.sv
// Port checks for the status/control block
`timescale 1ns/1ns
module psi_core_sva
    import psi_pkg::*;
(
    // Clock, reset, inputs
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       watchdog_cause_in,
    input wire logic       port_write_instruction_in,
    input wire logic [7:0] port_addr_in,
    input wire logic [7:0] port_wdata_in,
    input wire logic       stop_instruction_in,
    input wire logic       usb_dp_in,
    input wire logic       usb_dm_in,
    input wire logic       bus_activity_in,
    // Outputs
    input wire logic       run_out,
    input wire logic       suspend_out,
    input wire logic       irq_call_out,
    input wire logic [3:0] irq_vector_out,
    input wire logic       bus_reset_out
);
    logic susp_wr;
    logic idle;
    assign susp_wr = port_write_instruction_in && port_wdata_in[PSC_SUSPEND]
        && port_addr_in == PSI_ADDR_PSC;
    assign idle = !bus_activity_in && (usb_dp_in || usb_dm_in);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_stop;
        stop_instruction_in && run_out && !watchdog_cause_in |=> !run_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    property p_susp;
        idle[*3] ##0 (susp_wr && run_out && !watchdog_cause_in
            && !stop_instruction_in) |=> suspend_out && !run_out;
    endproperty
    a_susp: assert property (p_susp) else $error("no suspend");
    property p_wake;
        suspend_out && bus_activity_in |-> ##[1:4] !suspend_out;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_refuse;
        bus_activity_in[*3] ##0 (susp_wr && !suspend_out) |=> !suspend_out;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad suspend");
    property p_se0;
        (usb_dp_in || usb_dm_in)[*8] |-> !bus_reset_out;
    endproperty
    a_se0: assert property (p_se0) else $error("stray bus reset");
    property p_call;
        irq_call_out |-> irq_vector_out inside {[4'h1:4'hb]} ##1 !irq_call_out;
    endproperty
    a_call: assert property (p_call) else $error("bad call");
    property p_por;
        $rose(rstn_in) |-> run_out && !suspend_out && !irq_call_out;
    endproperty
    a_por: assert property (p_por) else $error("bad reset state");
    property p_wdog;
        watchdog_cause_in |=> run_out && !suspend_out;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog no run");
    c_call: cover property (irq_call_out && irq_vector_out == 4'h1);
    c_susp: cover property ($rose(suspend_out));
    c_bus: cover property (bus_reset_out);
endmodule // psi_core_sva

// File: cpu_status_and_irq_enables_test.sv
// Testbench for the status/control block
`timescale 1ns/1ns
module cpu_status_and_irq_enables_test
    import psi_pkg::*;
();
    localparam int SE0_SIM = 20;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        port_write_instruction_in, port_read_in;
    logic        usb_dp_in, usb_dm_in, bus_activity_in;
    logic [7:0]  port_addr_in, port_wdata_in, port_rdata_out;
    logic [4:0]  ins;
    logic [10:0] ev;
    logic        instr_end = 1'b1;
    logic        run_out, suspend_out, irq_call_out, bus_reset_out;
    logic [3:0]  irq_vector_out;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    // Address, write data, readback
    logic [23:0] rows [5] = '{24'h20ff77, 24'h21ff1f, 24'h42ff00,
                              24'hff6165, 24'hff8105};

    psi_core #(.SE0_CNT(SE0_SIM)) dut (
        .clk_in, .rstn_in, .watchdog_cause_in(ins[4]),
        .port_write_instruction_in, .port_read_in, .port_addr_in,
        .port_wdata_in, .port_rdata_out, .irq_off_instruction_in(ins[0]),
        .irq_on_instruction_in(ins[1]), .irq_return_instruction_in(ins[2]),
        .stop_instruction_in(ins[3]), .instr_end_in(instr_end), .usb_dp_in,
        .usb_dm_in, .bus_activity_in, .tick_128us_in(ev[1]),
        .tick_1024us_in(ev[2]), .endpoint_event_in(ev[7:3]),
        .dac_event_in(ev[8]), .gpio_event_in(ev[9]), .i2c_event_in(ev[10]),
        .run_out, .suspend_out, .irq_call_out, .irq_vector_out,
        .bus_reset_out
    );

    always #5 clk_in = ~clk_in;

    task automatic test_done;
        if (n_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_in);
        port_write_instruction_in <= 1'b1;
        port_addr_in <= a;
        port_wdata_in <= d;
        @(posedge clk_in);
        port_write_instruction_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, e);
        @(posedge clk_in);
        port_read_in <= 1'b1;
        port_addr_in <= a;
        @(posedge clk_in);
        port_read_in <= 1'b0;
        #1 chk("rdata", port_rdata_out, e);
    endtask

    task automatic go(input logic [4:0] i, input logic [10:0] e);
        @(posedge clk_in);
        ins <= i;
        ev <= e;
        @(posedge clk_in);
        ins <= '0;
        ev <= '0;
    endtask

    task automatic call(input logic [3:0] e);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while (irq_call_out !== 1'b1 && n < 20);
        chk("vector", {3'h0, irq_call_out, irq_vector_out}, {4'h1, e});
    endtask

    initial begin
        {ins, ev, port_write_instruction_in, port_read_in} = '0;
        {port_addr_in, port_wdata_in, usb_dm_in, bus_activity_in} = '0;
        usb_dp_in = 1'b1;
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd(PSI_ADDR_PSC, PSC_RESET_VAL);
        rd(PSI_ADDR_EIM, 8'h00);
        go(5'h02, '0);
        wr(PSI_ADDR_PSC, 8'h11);
        rd(PSI_ADDR_PSC, 8'h15);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        for (int i = 1; i < SRC_NUM; i++) begin
            go(5'h00, 11'(1) << i);
            call(4'(i + 1));
            go(5'h04, '0);
        end
        go(5'h00, 11'h20a);
        call(4'h2);
        rd(PSI_ADDR_PSC, 8'h81);
        go(5'h04, '0);
        call(4'h4);
        go(5'h02, '0);
        call(4'ha);
        rd(PSI_ADDR_PSC, 8'h01);
        wr(PSI_ADDR_GIM, 8'h00);
        go(5'h02, 11'h100);
        rd(PSI_ADDR_PSC, 8'h85);
        wr(PSI_ADDR_GIM, 8'h10);
        call(4'h9);
        wr(PSI_ADDR_GIM, 8'h01);
        go(5'h02, '0);
        usb_dp_in <= 1'b0;
        repeat (SE0_SIM + 10) @(posedge clk_in);
        usb_dp_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1 chk("busrst", {7'h0, bus_reset_out}, 8'h01);
        call(4'h1);
        rd(PSI_ADDR_PSC, 8'h21);
        wr(PSI_ADDR_PSC, 8'h05);
        usb_dp_in <= 1'b0;
        repeat (SE0_SIM - 10) @(posedge clk_in);
        usb_dm_in <= 1'b1;
        repeat (SE0_SIM * 2) @(posedge clk_in);
        {usb_dp_in, usb_dm_in} <= 2'b10;
        rd(PSI_ADDR_PSC, 8'h01);
        go(5'h02, '0);
        go(5'h01, '0);
        instr_end <= 1'b0;
        rd(PSI_ADDR_PSC, 8'h01);
        go(5'h02, 11'h008);
        rd(PSI_ADDR_PSC, 8'h85);
        @(posedge clk_in);
        instr_end <= 1'b1;
        call(4'h4);
        wr(PSI_ADDR_PSC, 8'h09);
        go(5'h00, 11'h010);
        @(posedge clk_in);
        #1 chk("irq wake", {suspend_out, run_out}, 8'h01);
        go(5'h02, '0);
        call(4'h5);
        wr(PSI_ADDR_PSC, 8'h09);
        #1 chk("suspend", {suspend_out, run_out}, 8'h02);
        @(posedge clk_in);
        bus_activity_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        #1 chk("wake", {suspend_out, run_out}, 8'h01);
        wr(PSI_ADDR_PSC, 8'h09);
        rd(PSI_ADDR_PSC, 8'h01);
        @(posedge clk_in);
        bus_activity_in <= 1'b0;
        wr(PSI_ADDR_PSC, 8'h21);
        go(5'h02, '0);
        go(5'h10, '0);
        rd(PSI_ADDR_PSC, 8'h61);
        rd(PSI_ADDR_GIM, 8'h00);
        go(5'h08, '0);
        rd(PSI_ADDR_PSC, 8'h00);
        chk("run", {7'h0, run_out}, 8'h00);
        @(posedge clk_in);
        rstn_in <= 1'b0;
        @(posedge clk_in);
        rstn_in <= 1'b1;
        go(5'h10, '0);
        rd(PSI_ADDR_PSC, 8'h51);
        test_done();
    end
endmodule // cpu_status_and_irq_enables_test

bind psi_core psi_core_sva u_sva (
    .clk_in, .rstn_in, .watchdog_cause_in, .port_write_instruction_in,
    .port_addr_in, .port_wdata_in, .stop_instruction_in, .usb_dp_in,
    .usb_dm_in, .bus_activity_in, .run_out, .suspend_out, .irq_call_out,
    .irq_vector_out, .bus_reset_out
);
